// >>> core/mpl_pkg.sv
package mpl_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 22;
   localparam int BASE_ADDR_W = 18;
   localparam int EXT_ADDR_W = 4;
   localparam int BYTE_W = 8;
   localparam int MODE_W = 3;
   localparam int PHASE_W = 3;

   // ----------------------------------------------------------------
   // Mode pin codes, pins two, one, zero
   // ----------------------------------------------------------------
   localparam logic [MODE_W-1:0] MODE_UP = 3'h4;
   localparam logic [MODE_W-1:0] MODE_DOWN = 3'h6;

   // ----------------------------------------------------------------
   // Start addresses and steps
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_UP_START = 22'h000000;
   localparam logic [ADDR_W-1:0] ADDR_DOWN_START = 22'h03ffff;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 22'h000001;

   // ----------------------------------------------------------------
   // Byte phases on the configuration clock
   // ----------------------------------------------------------------
   localparam logic [PHASE_W-1:0] PHASE_CAPTURE = 3'h0;
   localparam logic [PHASE_W-1:0] PHASE_STEP = 3'h1;
   localparam logic [PHASE_W-1:0] PHASE_LSB = 3'h2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 25;
   localparam int CFG_CLK_PERIOD_NS = 200;
   localparam int MIN_HALF_CYC = 4;

   typedef enum logic [1:0] {
      MPL_IDLE = 2'b00,
      MPL_RUN = 2'b01,
      MPL_DONE = 2'b11
   } mpl_state_e;
endpackage : mpl_pkg

// >>> core/mpl_loader.sv
`timescale 1ns/1ps
// Overview of operation
// - While loading, the block drives the memory address and takes the eight data bits on the rising configuration clock edge just before the address steps.
// - Every captured byte is serialised and sent out on the chain output so that preamble and surplus data reach the next device.
// - The rising edge that captures a byte also steps the memory address in that same cycle.
// - Bit zero of a captured byte appears on the chain output at the falling edge one and a half clock periods after the capturing rising edge.
// - While loading, the chain output changes only on falling configuration clock edges; the next device samples it on the next rising edge, lowest bit first.
// - Mode pins 100 select upward loading, starting at address 00000 and counting up after each byte.
// - Mode pins 110 select downward loading, starting at address 3ffff and counting down after each byte.
// - The four extended address lines are left undriven by default, giving plain 18-bit addressing.
// - The extended address lines are driven only once the bitstream setting asks for all 22 address lines.
// - During configuration the init status pin is open-drain: it is only ever pulled low, never driven high.
module mpl_loader
   import mpl_pkg::*;
#(
   parameter int CFG_PERIOD_NS = CFG_CLK_PERIOD_NS
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Sequencing from the configuration logic
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic i_wide_addressing_option,
   input wire logic i_mem_clear,
   input wire logic i_cfg_error,
   // Mode pins
   input wire logic i_mode_pin_two,
   input wire logic i_mode_pin_one,
   input wire logic i_mode_pin_zero,
   // Memory interface
   input wire logic [BYTE_W-1:0] i_prom_data,
   output logic [BASE_ADDR_W-1:0] o_prom_addr,
   output logic o_prom_addr_oe_n,
   output logic [EXT_ADDR_W-1:0] o_extended_address_lines,
   output logic o_ext_addr_oe_n,
   // Chain side
   output logic o_config_clock,
   output logic o_chain_out,
   // Init status pin, open drain
   output logic o_init_o,
   output logic o_init_oe_n,
   // Status
   output logic o_busy
);

   // ----------------------------------------------------------------
   // Derived timing
   // ----------------------------------------------------------------
   // Half period rounds down so the clock never runs slower than set
   localparam int HALF_CYC = CFG_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
   localparam int DIV_W = $clog2(HALF_CYC + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO = '0;
   localparam int LSB_DLY = 3 * HALF_CYC + 1;

   // Two synchroniser stages plus memory settle must fit in a half period
   if (HALF_CYC < MIN_HALF_CYC) begin : g_bad_period
      $error("Configuration clock period too short for this system clock");
   end

   mpl_state_e state_r;
   logic [1:0][BYTE_W-1:0] data_sync_r;
   logic [1:0][MODE_W-1:0] mode_sync_r;
   logic [BYTE_W-1:0] data_s;
   logic [MODE_W-1:0] mode_s;
   logic [DIV_W-1:0] div_r;
   logic config_clock_r;
   logic tick;
   logic rise_en;
   logic fall_en;
   logic [PHASE_W-1:0] phase_r;
   logic down_r;
   logic wide_r;
   logic [ADDR_W-1:0] addr_r;
   logic [BYTE_W-1:0] cap_r;
   logic [BYTE_W-1:0] shift_r;
   logic loaded_r;
   logic chain_r;
   logic ext_oe_n_r;
   logic base_oe_n_r;
   logic init_oe_n_r;
   logic start_ok;
   logic capture_now;
   logic capture_n_ok;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         data_sync_r <= '0;
         mode_sync_r <= '0;
      end else begin
         data_sync_r[0] <= i_prom_data;
         data_sync_r[1] <= data_sync_r[0];
         mode_sync_r[0] <= {i_mode_pin_two, i_mode_pin_one, i_mode_pin_zero};
         mode_sync_r[1] <= mode_sync_r[0];
      end
   end

   assign data_s = data_sync_r[1];
   assign mode_s = mode_sync_r[1];
   assign start_ok = i_start && (state_r != MPL_RUN) && ((mode_s == MODE_UP) || (mode_s == MODE_DOWN));

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_r <= MPL_IDLE;
      end else begin
         case (state_r)
            MPL_IDLE: begin
               if (start_ok) begin
                  state_r <= MPL_RUN;
               end
            end
            MPL_RUN: begin
               if (i_stop) begin
                  state_r <= MPL_DONE;
               end
            end
            MPL_DONE: begin
               if (start_ok) begin
                  state_r <= MPL_RUN;
               end
            end
            default: begin
               state_r <= MPL_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Configuration clock divider
   // ----------------------------------------------------------------
   assign tick = (state_r == MPL_RUN) && (div_r == DIV_LAST);
   assign rise_en = tick && !config_clock_r;
   assign fall_en = tick && config_clock_r;

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         div_r <= DIV_ZERO;
         config_clock_r <= 1'b0;
      end else if (state_r != MPL_RUN || start_ok) begin
         // Clock parks low outside a load
         div_r <= DIV_ZERO;
         config_clock_r <= 1'b0;
      end else if (tick) begin
         div_r <= DIV_ZERO;
         config_clock_r <= !config_clock_r;
      end else begin
         div_r <= div_r + DIV_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Byte phase and address
   // ----------------------------------------------------------------
   assign capture_now = rise_en && (phase_r == PHASE_CAPTURE);
   assign capture_n_ok = capture_now && !start_ok;

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         phase_r <= PHASE_CAPTURE;
         down_r <= 1'b0;
         wide_r <= 1'b0;
         addr_r <= ADDR_UP_START;
         cap_r <= '0;
      end else if (start_ok) begin
         phase_r <= PHASE_CAPTURE;
         wide_r <= 1'b0;
         if (mode_s == MODE_DOWN) begin
            down_r <= 1'b1;
            addr_r <= ADDR_DOWN_START;
         end else begin
            down_r <= 1'b0;
            addr_r <= ADDR_UP_START;
         end
      end else begin
         // Setting arrives from the bitstream part way through a load
         if (state_r == MPL_RUN && i_wide_addressing_option) begin
            wide_r <= 1'b1;
         end
         if (rise_en) begin
            phase_r <= phase_r + PHASE_W'(1);
         end
         if (capture_now) begin
            cap_r <= data_s;
            addr_r <= down_r ? addr_r - ADDR_STEP : addr_r + ADDR_STEP;
         end
      end
   end

   // ----------------------------------------------------------------
   // Serialiser
   // ----------------------------------------------------------------
   // Shift register reloads on its own falling edge, so the next capture
   // into cap_r never disturbs the bits still going out
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         shift_r <= '1;
         loaded_r <= 1'b0;
         chain_r <= 1'b1;
      end else if (state_r != MPL_RUN || start_ok) begin
         shift_r <= '1;
         loaded_r <= 1'b0;
         chain_r <= 1'b1;
      end else if (fall_en) begin
         if (phase_r == PHASE_LSB) begin
            chain_r <= cap_r[0];
            shift_r <= {1'b1, cap_r[BYTE_W-1:1]};
            loaded_r <= 1'b1;
         end else if (loaded_r) begin
            chain_r <= shift_r[0];
            shift_r <= {1'b1, shift_r[BYTE_W-1:1]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         ext_oe_n_r <= 1'b1;
         base_oe_n_r <= 1'b1;
      end else begin
         base_oe_n_r <= !(state_r == MPL_RUN);
         // Undriven lines rest on pull-ups; upward loads need board pull-downs
         ext_oe_n_r <= !(state_r == MPL_RUN && wide_r);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         init_oe_n_r <= 1'b1;
      end else begin
         init_oe_n_r <= !((state_r != MPL_DONE) && (i_mem_clear || i_cfg_error));
      end
   end

   assign o_prom_addr = addr_r[BASE_ADDR_W-1:0];
   assign o_extended_address_lines = addr_r[ADDR_W-1:BASE_ADDR_W];
   assign o_prom_addr_oe_n = base_oe_n_r;
   assign o_ext_addr_oe_n = ext_oe_n_r;
   assign o_config_clock = config_clock_r;
   assign o_chain_out = chain_r;
   assign o_init_o = 1'b0;
   assign o_init_oe_n = init_oe_n_r;
   assign o_busy = (state_r == MPL_RUN);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // Counts the cycles from a capture to the fall that must show bit zero,
   // since the wait is too long to unroll as a repetition
   localparam int LSB_W = $clog2(LSB_DLY + 1);
   localparam logic [LSB_W-1:0] LSB_LAST = LSB_W'(LSB_DLY);
   logic [LSB_W-1:0] lsb_wait_r;
   logic lsb_bit_r;

   always_ff @(posedge i_clk) begin
      if (!i_resetn || state_r != MPL_RUN) begin
         lsb_wait_r <= '0;
         lsb_bit_r <= 1'b0;
      end else if (capture_now) begin
         lsb_wait_r <= LSB_W'(1);
         lsb_bit_r <= data_s[0];
      end else if (lsb_wait_r != '0 && lsb_wait_r != LSB_LAST) begin
         lsb_wait_r <= lsb_wait_r + LSB_W'(1);
      end else begin
         lsb_wait_r <= '0;
      end
   end

   addr_step_a: assert property (capture_n_ok |=> addr_r == ($past(down_r) ? $past(addr_r) - ADDR_STEP
      : $past(addr_r) + ADDR_STEP))
      else $error("address did not step with the capture");

   byte_capture_a: assert property (capture_now && !start_ok |=> cap_r == $past(data_s))
      else $error("byte not captured on rising edge");

   chain_fall_a: assert property ($changed(chain_r) && $past(state_r) == MPL_RUN && $past(!start_ok)
      |-> $past(fall_en))
      else $error("chain output changed off a falling edge");

   lsb_delay_a: assert property (lsb_wait_r == LSB_LAST |-> chain_r == lsb_bit_r)
      else $error("bit zero late or wrong");

   bit_order_a: assert property (fall_en && loaded_r && phase_r != PHASE_LSB && !start_ok
      |=> chain_r == $past(shift_r[0]) && shift_r[BYTE_W-1] == 1'b1)
      else $error("serial bit order broken");

   up_start_a: assert property (start_ok && mode_s == MODE_UP |=> addr_r == ADDR_UP_START && !down_r)
      else $error("upward load started at wrong address");

   down_start_a: assert property (start_ok && mode_s == MODE_DOWN |=> addr_r == ADDR_DOWN_START && down_r)
      else $error("downward load started at wrong address");

   ext_idle_a: assert property (!wide_r |=> o_ext_addr_oe_n)
      else $error("extended lines driven without wide setting");

   ext_drive_a: assert property (!o_ext_addr_oe_n |-> $past(wide_r) && $past(state_r) == MPL_RUN)
      else $error("extended lines driven outside a wide load");

   init_pull_a: assert property (!o_init_oe_n |-> $past(i_mem_clear || i_cfg_error) && o_init_o == 1'b0)
      else $error("init pin driven without cause");

   up_load_c: cover property (start_ok && mode_s == MODE_UP ##[1:200] capture_now);
   down_load_c: cover property (start_ok && mode_s == MODE_DOWN ##[1:200] capture_now);
   lsb_out_c: cover property (fall_en && phase_r == PHASE_LSB ##1 !chain_r);
   wide_c: cover property ($fell(o_ext_addr_oe_n));

endmodule : mpl_loader

// >>> test/mpl_prom_model.sv
`timescale 1ns/1ps
module mpl_prom_model
   import mpl_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Board strapping
   input wire logic i_pull_down_fit,
   // Address pins
   input wire logic [BASE_ADDR_W-1:0] i_addr,
   input wire logic i_addr_oe_n,
   input wire logic [EXT_ADDR_W-1:0] i_ext,
   input wire logic i_ext_oe_n,
   // Data pins
   output logic [BYTE_W-1:0] o_data
);
   logic [EXT_ADDR_W-1:0] ext_w;
   logic [BYTE_W-1:0] mem_w;
   logic [BYTE_W-1:0] stale_r = 8'h00;

   // Undriven extended lines sit at the board pull-down, else the internal pull-up
   assign ext_w = i_ext_oe_n ? (i_pull_down_fit ? 4'h0 : 4'hf) : i_ext;
   assign mem_w = i_addr[7:0] ^ {ext_w, i_addr[17:14]} ^ 8'h3c;
   // Deselected data pins toggle so a stale byte can never pass for a good one
   assign o_data = i_addr_oe_n ? stale_r : mem_w;

   always_ff @(posedge i_clk) begin
      stale_r <= ~o_data;
   end
endmodule : mpl_prom_model

// >>> test/mpl_loader_tb_top.sv
`timescale 1ns/1ps
module mpl_loader_tb_top;
   import mpl_pkg::*;
   localparam int HALF = CFG_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS / 2;
   logic i_clk, i_resetn, i_start, i_stop, i_wide, i_mem_clear, i_cfg_error, pull_down_fit;
   logic [MODE_W-1:0] mode;
   logic [BYTE_W-1:0] prom_data;
   logic [BASE_ADDR_W-1:0] prom_addr;
   logic [EXT_ADDR_W-1:0] ext;
   logic addr_oe_n, ext_oe_n, cfg_clk, chain, init_o, init_oe_n, busy, init_pin;
   int n_errors = 0;
   int compares = 0;

   assign init_pin = init_oe_n ? 1'b1 : init_o;

   mpl_loader u_mpl_loader (.i_clk(i_clk), .i_resetn(i_resetn), .i_start(i_start), .i_stop(i_stop),
      .i_wide_addressing_option(i_wide), .i_mem_clear(i_mem_clear), .i_cfg_error(i_cfg_error),
      .i_mode_pin_two(mode[2]), .i_mode_pin_one(mode[1]), .i_mode_pin_zero(mode[0]),
      .i_prom_data(prom_data), .o_prom_addr(prom_addr), .o_prom_addr_oe_n(addr_oe_n),
      .o_extended_address_lines(ext), .o_ext_addr_oe_n(ext_oe_n), .o_config_clock(cfg_clk),
      .o_chain_out(chain), .o_init_o(init_o), .o_init_oe_n(init_oe_n), .o_busy(busy));

   mpl_prom_model u_mpl_prom_model (.i_clk(i_clk), .i_pull_down_fit(pull_down_fit), .i_addr(prom_addr),
      .i_addr_oe_n(addr_oe_n), .i_ext(ext), .i_ext_oe_n(ext_oe_n), .o_data(prom_data));

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   function automatic logic [7:0] mem_byte(input logic [21:0] a);
      return a[7:0] ^ {a[21:18], a[17:14]} ^ 8'h3c;
   endfunction : mem_byte

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   // Loads three bytes and follows the chain as the next device would
   task automatic run_stream(input logic [2:0] md, input logic wide, input logic [21:0] a0, input logic down);
      logic pc, pd;
      int rise, j;
      logic [21:0] a, ab;
      logic [7:0] eb;
      rise = 0;
      @(posedge i_clk);
      mode <= md;
      repeat (3) @(posedge i_clk);
      i_start <= 1'b1;
      @(posedge i_clk);
      i_start <= 1'b0;
      i_wide <= wide;
      @(negedge i_clk);
      check(busy, 1);
      check(prom_addr, a0[17:0]);
      // Address enable is registered from the run state, one cycle behind busy
      @(negedge i_clk);
      check(addr_oe_n, 0);
      pc = cfg_clk;
      pd = chain;
      repeat (40 * HALF) begin
         @(negedge i_clk);
         if (chain !== pd && !(pc && !cfg_clk)) check(chain, pd);
         if (!pc && cfg_clk) begin
            rise++;
            a = down ? a0 - 22'((rise + 7) / 8) : a0 + 22'((rise + 7) / 8);
            check(prom_addr, a[17:0]);
            check(ext_oe_n, !wide);
            if (wide) check(ext, a[21:18]);
            if (rise >= 3) begin
               j = rise - 3;
               ab = down ? a0 - 22'(j / 8) : a0 + 22'(j / 8);
               // The first byte is read before the wide setting drives the upper lines
               if (!wide || j < 8) ab[21:18] = pull_down_fit ? 4'h0 : 4'hf;
               eb = mem_byte(ab);
               check(chain, eb[j % 8]);
            end
         end
         pc = cfg_clk;
         pd = chain;
      end
      check(rise, 20);
      @(posedge i_clk);
      i_stop <= 1'b1;
      i_wide <= 1'b0;
      @(posedge i_clk);
      i_stop <= 1'b0;
      repeat (2) @(negedge i_clk);
      check({busy, cfg_clk, chain, addr_oe_n, ext_oe_n}, 5'h07);
   endtask : run_stream

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_init();
      @(posedge i_clk);
      i_mem_clear <= 1'b1;
      repeat (2) @(negedge i_clk);
      check(init_pin, 0);
      check(init_o, 0);
      @(posedge i_clk);
      i_mem_clear <= 1'b0;
      i_cfg_error <= 1'b1;
      repeat (2) @(negedge i_clk);
      check(init_oe_n, 0);
      @(posedge i_clk);
      i_cfg_error <= 1'b0;
      repeat (2) @(negedge i_clk);
      check(init_pin, 1);
      $display("test_init done");
   endtask : test_init

   task automatic test_refused();
      @(posedge i_clk);
      mode <= 3'h5;
      repeat (3) @(posedge i_clk);
      i_start <= 1'b1;
      @(posedge i_clk);
      i_start <= 1'b0;
      repeat (3) @(negedge i_clk);
      check({busy, addr_oe_n}, 2'h1);
      $display("test_refused done");
   endtask : test_refused

   task automatic test_up();
      pull_down_fit = 1'b1;
      run_stream(MODE_UP, 1'b0, 22'h000000, 1'b0);
      $display("test_up done");
   endtask : test_up

   task automatic test_down();
      pull_down_fit = 1'b0;
      run_stream(MODE_DOWN, 1'b1, 22'h03ffff, 1'b1);
      $display("test_down done");
   endtask : test_down

   // ----------------------------------------------------------------
   // Clock, sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   initial begin
      i_resetn = 1'b0;
      i_start = 1'b0;
      i_stop = 1'b0;
      i_wide = 1'b0;
      i_mem_clear = 1'b0;
      i_cfg_error = 1'b0;
      pull_down_fit = 1'b1;
      mode = 3'h0;
      repeat (8) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(negedge i_clk);
      check({busy, cfg_clk, chain, addr_oe_n, ext_oe_n, init_oe_n}, 6'h0f);
      test_init();
      test_refused();
      test_up();
      test_down();
      tally_and_finish();
   end

   // Two loads take about 340 cycles; allow well over that
   initial begin
      #(SYS_CLK_PERIOD_NS * 5000);
      n_errors++;
      tally_and_finish();
   end
endmodule : mpl_loader_tb_top
